// *** core/adc_power_sync_ref_config_regs_regs.vh ***
// Register offsets, field positions, reset values and serial frame length for the configuration slice
`ifndef ADC_POWER_SYNC_REF_CONFIG_REGS_REGS_VH
`define ADC_POWER_SYNC_REF_CONFIG_REGS_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_OUTPUT_BUFFER_POWER_DOWN 8'h09
`define OFS_GLOBAL_POWER_DOWN_MASK 8'h0D
`define OFS_PIN_FUNCTION_REFERENCE_CLOCK_SELECT 8'h0E
`define OFS_SAMPLING_DELAY_AUTOZERO_CONTROL 8'h11
`define OFS_POWER_CONTROL 8'h08

// ----------------------------------------
// Reset value
// ----------------------------------------
`define REG_RESET 8'h00

// ----------------------------------------
// Output buffer power-down fields
// ----------------------------------------
`define BIT_FRAME_CLOCK_BUFFER_OFF 5
`define BIT_BIT_CLOCK_BUFFER_OFF 4
`define BIT_CHAN_A_LANE1_OFF 3
`define BIT_CHAN_A_LANE0_OFF 2
`define BIT_CHAN_B_LANE1_OFF 1
`define BIT_CHAN_B_LANE0_OFF 0

// ----------------------------------------
// Global power-down mask fields
// ----------------------------------------
`define BIT_KEEP_CLOCK_BUFFER_ON 3
`define BIT_KEEP_REFERENCE_AMP_ON 2
`define BIT_BANDGAP_OFF_IN_STANDBY 1

// ----------------------------------------
// Pin function / reference / clock fields
// ----------------------------------------
`define BIT_PIN_IS_ALIGN 7
`define BIT_SOFT_ALIGN 6
`define BIT_SOFT_ALIGN_ENABLE 5
`define BIT_REFERENCE_CONTROL_SOURCE 3
`define BIT_REF_SELECT_HI 2
`define BIT_REF_SELECT_LO 1
`define BIT_SINGLE_ENDED_CLOCK_SELECT 0

// Reference source codes
`define REF_INTERNAL 2'h0
`define REF_EXT_BUFFERED 2'h1
`define REF_EXT_DIRECT 2'h2

// ----------------------------------------
// Sampling delay / auto-zero fields
// ----------------------------------------
`define BIT_DELAY_LOOP_POWER_DOWN 2
`define BIT_AUTO_ZERO_CONTROL 0

// ----------------------------------------
// Serial port framing
// ----------------------------------------
`define SERIAL_FRAME_BITS 16

`endif

// *** core/serial_port_slave.v ***
// Serial control port slave: 16-bit frames of read flag, 7-bit address, 8-bit data
`include "adc_power_sync_ref_config_regs_regs.vh"

module serial_port_slave (
  input wire clk,
  input wire srst,
  input wire portSelectN,
  input wire portClock,
  input wire portDataIn,
  input wire [7:0] readData,
  output reg portDataOut,
  output reg writeStrobe,
  output reg [7:0] address,
  output reg [7:0] writeData
);

  reg [4:0] bitCount;
  reg [14:0] shiftIn;
  reg [7:0] shiftOut;
  reg isRead;
  reg clockLast;
  wire clockRise;
  wire clockFall;

  assign clockRise = portClock & ~clockLast;
  assign clockFall = ~portClock & clockLast;

  // Shift in on rising serial clock, shift out on falling
  always @(posedge clk) begin
    if (srst) begin
      bitCount <= 5'h00;
      shiftIn <= 15'h0000;
      shiftOut <= 8'h00;
      isRead <= 1'b0;
      clockLast <= 1'b0;
      portDataOut <= 1'b0;
      writeStrobe <= 1'b0;
      address <= 8'h00;
      writeData <= 8'h00;
    end else begin
      clockLast <= portClock;
      writeStrobe <= 1'b0;
      if (portSelectN) begin
        bitCount <= 5'h00;
      end else if (clockRise) begin
        shiftIn <= {shiftIn[13:0], portDataIn};
        bitCount <= bitCount + 5'h01;
        if (bitCount == 5'h07) begin
          // Address complete: latch it and the read flag
          isRead <= shiftIn[6];
          address <= {1'b0, shiftIn[5:0], portDataIn};
        end
        if (bitCount == 5'h0F && !isRead) begin
          writeData <= {shiftIn[6:0], portDataIn};
          writeStrobe <= 1'b1;
        end
      end else if (clockFall && bitCount == 5'h08) begin
        // Address is latched by now, so the read mux shows the addressed register
        portDataOut <= readData[7];
        shiftOut <= {readData[6:0], 1'b0};
      end else if (clockFall && bitCount > 5'h08 && bitCount < 5'h10) begin
        portDataOut <= shiftOut[7];
        shiftOut <= {shiftOut[6:0], 1'b0};
      end
    end
  end

endmodule // serial_port_slave

// *** core/align_pulse_gen.v ***
// Turns a level into a one-cycle pulse on its rising edge
module align_pulse_gen (
  input wire clk,
  input wire srst,
  input wire level,
  output reg pulse
);

  reg levelLast;

  // Edge detect on the level
  always @(posedge clk) begin
    if (srst) begin
      levelLast <= 1'b0;
      pulse <= 1'b0;
    end else begin
      levelLast <= level;
      pulse <= level & ~levelLast;
    end
  end

endmodule // align_pulse_gen

// *** core/adc_power_sync_ref_config_regs.v ***
// Power-down, alignment, reference and clock configuration registers of the converter
`include "adc_power_sync_ref_config_regs_regs.vh"

module adc_power_sync_ref_config_regs (
  input wire clk,
  input wire srst,
  input wire portSelectN,
  input wire portClock,
  input wire portDataIn,
  output reg portDataOut,
  input wire shared_align_powerdown_pin,
  input wire reference_buffer_pin,
  input wire wholeChipPowerDownBit,
  input wire [1:0] laneModeSelect,
  output reg frame_clock_out_en,
  output reg bit_clock_out_en,
  output reg chanALane1En,
  output reg chanALane0En,
  output reg chanBLane1En,
  output reg chanBLane0En,
  output reg standbyActive,
  output reg clockBufferOn,
  output reg referenceAmpOn,
  output reg bandgapOn,
  output reg alignPulse,
  output reg [1:0] referenceSource,
  output reg referenceFromPin,
  output reg singleEndedClock,
  output reg differentialClockBufferOn,
  output reg halfPeriodSampling,
  output reg autoZeroBit
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [7:0] regFile [0:3];
  reg [7:0] readData;
  reg [1:0] wrIndex;
  reg wrHit;
  wire writeStrobe;
  wire [7:0] address;
  wire [7:0] writeData;
  wire softPulse;
  wire pinPulse;
  reg softAlignLevel;
  reg pinAlignLevel;
  reg [7:0] outPd;
  reg [7:0] mask;
  reg [7:0] pinRef;
  reg [7:0] dll;

  // Map an address to a storage index and a hit flag
  function [2:0] decode;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_OUTPUT_BUFFER_POWER_DOWN: decode = 3'h4;
        `OFS_GLOBAL_POWER_DOWN_MASK: decode = 3'h5;
        `OFS_PIN_FUNCTION_REFERENCE_CLOCK_SELECT: decode = 3'h6;
        `OFS_SAMPLING_DELAY_AUTOZERO_CONTROL: decode = 3'h7;
        default: decode = 3'h0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  wire portOut;

  serial_port_slave serialPort (
    .clk(clk),
    .srst(srst),
    .portSelectN(portSelectN),
    .portClock(portClock),
    .portDataIn(portDataIn),
    .readData(readData),
    .portDataOut(portOut),
    .writeStrobe(writeStrobe),
    .address(address),
    .writeData(writeData)
  );

  // Read mux; unmapped addresses read zero
  always @* begin
    {wrHit, wrIndex} = decode(address);
    if (wrHit) begin
      readData = regFile[wrIndex];
    end else begin
      readData = `REG_RESET;
    end
  end

  // Registers take the written value at the end of the frame
  always @(posedge clk) begin
    if (srst) begin
      regFile[0] <= `REG_RESET;
      regFile[1] <= `REG_RESET;
      regFile[2] <= `REG_RESET;
      regFile[3] <= `REG_RESET;
    end else if (writeStrobe && wrHit) begin
      regFile[wrIndex] <= writeData;
    end
  end

  // Named views of the storage
  always @* begin
    outPd = regFile[0];
    mask = regFile[1];
    pinRef = regFile[2];
    dll = regFile[3];
  end

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  reg frameClockOff;
  reg bitClockOff;
  reg chanALane1Off;
  reg chanALane0Off;
  reg chanBLane1Off;
  reg chanBLane0Off;
  reg keepClockBuffer;
  reg keepReferenceAmp;
  reg bandgapOffInStandby;
  reg pinIsAlign;
  reg softAlignBit;
  reg softAlignEnable;
  reg referenceControlSource;
  reg [1:0] referenceSelect;
  reg singleEndedSelect;
  reg delayLoopPowerDown;
  reg autoZeroControl;

  // Output power-down fields
  always @* begin
    frameClockOff = outPd[`BIT_FRAME_CLOCK_BUFFER_OFF];
    bitClockOff = outPd[`BIT_BIT_CLOCK_BUFFER_OFF];
    chanALane1Off = outPd[`BIT_CHAN_A_LANE1_OFF];
    chanALane0Off = outPd[`BIT_CHAN_A_LANE0_OFF];
    chanBLane1Off = outPd[`BIT_CHAN_B_LANE1_OFF];
    chanBLane0Off = outPd[`BIT_CHAN_B_LANE0_OFF];
  end

  // Standby mask fields
  always @* begin
    keepClockBuffer = mask[`BIT_KEEP_CLOCK_BUFFER_ON];
    keepReferenceAmp = mask[`BIT_KEEP_REFERENCE_AMP_ON];
    bandgapOffInStandby = mask[`BIT_BANDGAP_OFF_IN_STANDBY];
  end

  // Pin function, reference and clock fields
  always @* begin
    pinIsAlign = pinRef[`BIT_PIN_IS_ALIGN];
    softAlignBit = pinRef[`BIT_SOFT_ALIGN];
    softAlignEnable = pinRef[`BIT_SOFT_ALIGN_ENABLE];
    referenceControlSource = pinRef[`BIT_REFERENCE_CONTROL_SOURCE];
    referenceSelect = pinRef[`BIT_REF_SELECT_HI:`BIT_REF_SELECT_LO];
    singleEndedSelect = pinRef[`BIT_SINGLE_ENDED_CLOCK_SELECT];
  end

  // Sampling delay and auto-zero fields
  always @* begin
    delayLoopPowerDown = dll[`BIT_DELAY_LOOP_POWER_DOWN];
    autoZeroControl = dll[`BIT_AUTO_ZERO_CONTROL];
  end

  // ----------------------------------------
  // Alignment sources
  // ----------------------------------------
  always @* begin
    softAlignLevel = softAlignBit & softAlignEnable;
    pinAlignLevel = shared_align_powerdown_pin & pinIsAlign & ~softAlignEnable;
  end

  align_pulse_gen softEdge (
    .clk(clk),
    .srst(srst),
    .level(softAlignLevel),
    .pulse(softPulse)
  );

  align_pulse_gen pinEdge (
    .clk(clk),
    .srst(srst),
    .level(pinAlignLevel),
    .pulse(pinPulse)
  );

  // ----------------------------------------
  // Output decode, all registered
  // ----------------------------------------
  reg next_standby;
  reg [5:0] next_bufferEnable;
  reg [2:0] next_blockOn;
  reg next_alignPulse;
  reg [1:0] next_referenceSource;
  reg next_referenceFromPin;
  reg next_singleEndedClock;

  // Block stays on while awake, or in standby when its mask keeps it
  function block_on;
    input standby;
    input keep;
    begin
      block_on = ~standby | keep;
    end
  endfunction

  // Pin enters standby only when it is not set up as alignment
  always @* begin
    next_standby = wholeChipPowerDownBit | (shared_align_powerdown_pin & ~pinIsAlign);
  end

  // Lane mode input is deliberately ignored: only the stored bits turn buffers off
  always @* begin
    next_bufferEnable[5] = ~frameClockOff;
    next_bufferEnable[4] = ~bitClockOff;
    next_bufferEnable[3] = ~chanALane1Off;
    next_bufferEnable[2] = ~chanALane0Off;
    next_bufferEnable[1] = ~chanBLane1Off;
    next_bufferEnable[0] = ~chanBLane0Off;
  end

  // Clock buffer, reference amplifier and bandgap under standby
  always @* begin
    next_blockOn[2] = block_on(next_standby, keepClockBuffer);
    next_blockOn[1] = block_on(next_standby, keepReferenceAmp);
    next_blockOn[0] = block_on(next_standby, ~bandgapOffInStandby);
  end

  // Alignment command from either source
  always @* begin
    next_alignPulse = softPulse | pinPulse;
  end

  // Register control picks reference and clock input; otherwise the reference-buffer pin picks the reference and the clock is differential
  always @* begin
    if (referenceControlSource) begin
      next_referenceFromPin = 1'b0;
      next_referenceSource = referenceSelect;
      next_singleEndedClock = singleEndedSelect;
    end else begin
      next_referenceFromPin = 1'b1;
      next_referenceSource = reference_buffer_pin ? `REF_EXT_BUFFERED : `REF_INTERNAL;
      next_singleEndedClock = 1'b0;
    end
  end

  // Serial read data
  always @(posedge clk) begin
    if (srst) begin
      portDataOut <= 1'b0;
    end else begin
      portDataOut <= portOut;
    end
  end

  // Output buffer enables
  always @(posedge clk) begin
    if (srst) begin
      frame_clock_out_en <= 1'b0;
      bit_clock_out_en <= 1'b0;
      chanALane1En <= 1'b0;
      chanALane0En <= 1'b0;
      chanBLane1En <= 1'b0;
      chanBLane0En <= 1'b0;
    end else begin
      frame_clock_out_en <= next_bufferEnable[5];
      bit_clock_out_en <= next_bufferEnable[4];
      chanALane1En <= next_bufferEnable[3];
      chanALane0En <= next_bufferEnable[2];
      chanBLane1En <= next_bufferEnable[1];
      chanBLane0En <= next_bufferEnable[0];
    end
  end

  // Standby state and block enables
  always @(posedge clk) begin
    if (srst) begin
      standbyActive <= 1'b0;
      clockBufferOn <= 1'b0;
      referenceAmpOn <= 1'b0;
      bandgapOn <= 1'b0;
    end else begin
      standbyActive <= next_standby;
      clockBufferOn <= next_blockOn[2];
      referenceAmpOn <= next_blockOn[1];
      bandgapOn <= next_blockOn[0];
    end
  end

  // One-cycle alignment output
  always @(posedge clk) begin
    if (srst) begin
      alignPulse <= 1'b0;
    end else begin
      alignPulse <= next_alignPulse;
    end
  end

  // Reference and clock input selection
  always @(posedge clk) begin
    if (srst) begin
      referenceSource <= `REF_INTERNAL;
      referenceFromPin <= 1'b0;
      singleEndedClock <= 1'b0;
      differentialClockBufferOn <= 1'b0;
    end else begin
      referenceSource <= next_referenceSource;
      referenceFromPin <= next_referenceFromPin;
      singleEndedClock <= next_singleEndedClock;
      differentialClockBufferOn <= ~next_singleEndedClock;
    end
  end

  // Sampling delay and auto-zero bits
  always @(posedge clk) begin
    if (srst) begin
      halfPeriodSampling <= 1'b0;
      autoZeroBit <= 1'b0;
    end else begin
      halfPeriodSampling <= delayLoopPowerDown;
      autoZeroBit <= autoZeroControl;
    end
  end

endmodule // adc_power_sync_ref_config_regs

// *** test/power_cfg_monitor.sv ***
// Concurrent checks on the configuration slice outputs
module power_cfg_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic wholeChipPowerDownBit,
  input wire logic shared_align_powerdown_pin,
  input wire logic reference_buffer_pin,
  input wire logic standbyActive,
  input wire logic clockBufferOn,
  input wire logic referenceAmpOn,
  input wire logic bandgapOn,
  input wire logic alignPulse,
  input wire logic [1:0] referenceSource,
  input wire logic referenceFromPin,
  input wire logic singleEndedClock,
  input wire logic differentialClockBufferOn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up;
  logic ready;
  // Edges since reset; outputs settle from the third one
  always @(posedge clk) begin
    if (srst) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  assign ready = (up == 2'h3);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence pdn_held;
    wholeChipPowerDownBit ##1 wholeChipPowerDownBit;
  endsequence
  sequence quiet_held;
    (!wholeChipPowerDownBit && !shared_align_powerdown_pin) ##1 (!wholeChipPowerDownBit && !shared_align_powerdown_pin);
  endsequence
  standby_entry_a: assert property ((ready ##0 pdn_held) |=> standbyActive) else $error("standby missed");
  standby_exit_a: assert property ((ready ##0 quiet_held) |=> !standbyActive) else $error("standby stuck");
  standby_cause_a: assert property ($rose(standbyActive) |-> $past(wholeChipPowerDownBit) || $past(shared_align_powerdown_pin))
    else $error("standby without cause");
  awake_blocks_a: assert property (ready && !standbyActive && !$past(standbyActive) |-> clockBufferOn && referenceAmpOn && bandgapOn)
    else $error("block off while awake");
  diff_clock_a: assert property (ready |-> differentialClockBufferOn != singleEndedClock) else $error("clock buffer wrong");
  pin_ref_a: assert property (ready && referenceFromPin |-> !singleEndedClock && !referenceSource[1]) else $error("pin ref wrong");
  pin_follow_a: assert property (($stable(reference_buffer_pin)[*3] ##0 (ready && referenceFromPin && $past(referenceFromPin)))
    |-> referenceSource == {1'b0, reference_buffer_pin}) else $error("ref source wrong");
  pulse_width_a: assert property (alignPulse |=> !alignPulse) else $error("pulse too long");
endmodule // power_cfg_monitor
bind adc_power_sync_ref_config_regs power_cfg_monitor mon_u (.clk(clk), .srst(srst),
  .wholeChipPowerDownBit(wholeChipPowerDownBit), .shared_align_powerdown_pin(shared_align_powerdown_pin),
  .reference_buffer_pin(reference_buffer_pin), .standbyActive(standbyActive), .clockBufferOn(clockBufferOn),
  .referenceAmpOn(referenceAmpOn), .bandgapOn(bandgapOn), .alignPulse(alignPulse), .referenceSource(referenceSource),
  .referenceFromPin(referenceFromPin), .singleEndedClock(singleEndedClock),
  .differentialClockBufferOn(differentialClockBufferOn));

// *** test/host_port_model.sv ***
// Host model: clocks 16-bit frames into the serial control port
module host_port_model (
  input wire logic clk,
  output logic portSelectN,
  output logic portClock,
  output logic portDataIn,
  input wire logic portDataOut
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    portSelectN = 1'b1;
    portClock = 1'b0;
    portDataIn = 1'b0;
  end
  // One frame, four clk per serial phase; read bits taken before each rise
  task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {rd, a, d};
    q = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk);
      portDataIn = w[i];
      portSelectN = 1'b0;
      repeat (3) @(negedge clk);
      q = {q[6:0], portDataOut};
      portClock = 1'b1;
      repeat (4) @(negedge clk);
      portClock = 1'b0;
    end
    repeat (4) @(negedge clk);
    portSelectN = 1'b1;
    portDataIn = ~portDataIn; // Released line shows no stale bit
    repeat (2) @(negedge clk);
  endtask
endmodule // host_port_model

// *** test/tb.sv ***
// Self-checking bench for the configuration slice
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, sharedPin = 0, refPin = 0, pdnBit = 0;
  logic [1:0] laneMode = 2'h0;
  logic [7:0] q, d, pulses = 8'h00, n;
  int seed = 46, err_total = 0, check_count = 0;
  wire sn, sc, sdi, sdo, fE, bE, a1, a0, b1, b0, stby, cb, ra, bg, pul, fromPin, se, dif, half, az;
  wire [1:0] src;
  always #5 clk = ~clk;
  adc_power_sync_ref_config_regs dut_u (.clk(clk), .srst(srst), .portSelectN(sn), .portClock(sc),
    .portDataIn(sdi), .portDataOut(sdo), .shared_align_powerdown_pin(sharedPin), .reference_buffer_pin(refPin),
    .wholeChipPowerDownBit(pdnBit), .laneModeSelect(laneMode), .frame_clock_out_en(fE), .bit_clock_out_en(bE),
    .chanALane1En(a1), .chanALane0En(a0), .chanBLane1En(b1), .chanBLane0En(b0), .standbyActive(stby),
    .clockBufferOn(cb), .referenceAmpOn(ra), .bandgapOn(bg), .alignPulse(pul), .referenceSource(src),
    .referenceFromPin(fromPin), .singleEndedClock(se), .differentialClockBufferOn(dif),
    .halfPeriodSampling(half), .autoZeroBit(az));
  host_port_model host_u (.clk(clk), .portSelectN(sn), .portClock(sc), .portDataIn(sdi), .portDataOut(sdo));
  // Count alignment pulses
  always @(posedge clk) if (pul === 1'b1) pulses <= pulses + 8'h01;
  function automatic logic [5:0] lane_en(input logic [7:0] r); return ~r[5:0]; endfunction
  function automatic logic [2:0] kept(input logic [7:0] m); return {m[3], m[2], ~m[1]}; endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v); host_u.frame(1'b0, a, v, q); endtask
  task automatic rd(input logic [6:0] a); host_u.frame(1'b1, a, 8'h00, q); endtask
  task automatic step(input int k); repeat (k) @(negedge clk); endtask
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #500000;
    err_total++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    step(16);
    srst = 0;
    step(2);
    rd(7'h09); chk(q, 8'h00);
    rd(7'h0D); chk(q, 8'h00);
    rd(7'h0E); chk(q, 8'h00);
    rd(7'h11); chk(q, 8'h00);
    chk({fE, bE, a1, a0, b1, b0}, 8'h3F);
    for (int i = 0; i < 5; i++) begin
      d = (i == 0) ? 8'h3F : $random(seed) & 8'h3F;
      laneMode = $random(seed);
      wr(7'h09, d);
      chk({fE, bE, a1, a0, b1, b0}, lane_en(d));
      rd(7'h09); chk(q, d);
    end
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'h0E : $random(seed) & 8'h0E; // Bandgap bit set for slow wake-up
      wr(7'h0D, d);
      pdnBit = 1;
      step(3);
      chk({stby, cb, ra, bg}, {1'b1, kept(d)});
      pdnBit = 0;
      step(3);
      chk({stby, cb, ra, bg}, 8'h07);
    end
    for (int s = 0; s < 6; s++) begin
      wr(7'h0E, 8'h08 | (s[2:1] << 1) | s[0]);
      chk({src, fromPin, se, dif}, {s[2:1], 1'b0, s[0], ~s[0]});
    end
    wr(7'h0E, 8'h01);
    for (int p = 0; p < 2; p++) begin
      refPin = p[0];
      step(3);
      chk({src, fromPin, se, dif}, {1'b0, p[0], 3'h5});
    end
    n = pulses;
    wr(7'h0E, 8'h40);
    wr(7'h0E, 8'h00);
    chk(pulses - n, 8'h00);
    wr(7'h0E, 8'h20);
    wr(7'h0E, 8'h60);
    wr(7'h0E, 8'h20); // Host writes the bit back
    chk(pulses - n, 8'h01);
    wr(7'h0E, 8'h00);
    sharedPin = 1;
    step(3);
    chk({stby, 7'(pulses - n)}, {1'b1, 7'h01});
    sharedPin = 0;
    wr(7'h0E, 8'h80);
    sharedPin = 1;
    step(4);
    chk({stby, 7'(pulses - n)}, {1'b0, 7'h02});
    sharedPin = 0;
    wr(7'h11, 8'h04); // Only for low sample rates
    chk({half, az}, 8'h02);
    wr(7'h11, 8'h01);
    rd(7'h11);
    chk(q, 8'h01);
    chk({half, az}, 8'h01);
    wr(7'h20, 8'hA5);
    rd(7'h20); chk(q, 8'h00);
    report_and_stop;
  end
endmodule // tb
